// File: core/fcl_pkg.sv
// fcl_pkg: constants, types and states of the flash configuration loader
package fcl_pkg;

    // -------------------------------------------------------------------
    // address map
    // -------------------------------------------------------------------
    localparam logic [23:0] FCL_CFG_BASE    = 24'hF80000; // first location
    localparam logic [23:0] FCL_SPACE_LO    = 24'h800000; // config space lo
    localparam logic [23:0] FCL_SPACE_HI    = 24'hFFFFFF; // config space hi
    localparam logic [23:0] FCL_LOC_STEP    = 24'h000002; // word spacing
    localparam int          FCL_LOC_COUNT   = 5;          // unpacked slots

    // word 1 and word 2 addresses per memory size
    localparam logic [23:0] FCL_W1_16K      = 24'h002BFE;
    localparam logic [23:0] FCL_W2_16K      = 24'h002BFC;
    localparam logic [23:0] FCL_W1_32K      = 24'h0057FE;
    localparam logic [23:0] FCL_W2_32K      = 24'h0057FC;
    localparam logic [23:0] FCL_W1_48K      = 24'h0083FE;
    localparam logic [23:0] FCL_W2_48K      = 24'h0083FC;
    localparam logic [23:0] FCL_W1_64K      = 24'h00ABFE;
    localparam logic [23:0] FCL_W2_64K      = 24'h00ABFC;

    // memory size strap codes
    localparam logic [1:0]  FCL_SIZE_16K    = 2'h0;
    localparam logic [1:0]  FCL_SIZE_32K    = 2'h1;
    localparam logic [1:0]  FCL_SIZE_48K    = 2'h2;

    // -------------------------------------------------------------------
    // word 1 field positions and values
    // -------------------------------------------------------------------
    localparam int          FCL_BIT_RSV_HI  = 15;  // must be programmed 0
    localparam int          FCL_BIT_SCAN    = 14;
    localparam int          FCL_BIT_CPROT   = 13;
    localparam int          FCL_BIT_WPROT   = 12;
    localparam int          FCL_BIT_DEBUG   = 11;
    localparam int          FCL_BIT_RSV_LO  = 10;  // must stay 1
    localparam int          FCL_PAIR_LO     = 8;
    localparam int          FCL_BIT_WDTEN   = 7;
    localparam int          FCL_BIT_WINDOW_WATCHDOG_DISABLE  = 6;
    localparam int          FCL_BIT_PRESC   = 4;
    localparam int          FCL_POST_LO     = 0;
    localparam int          FCL_UPPER_LO    = 16;  // upper byte, unused

    localparam logic [23:0] FCL_ERASED      = 24'hFFFFFF; // erased word
    localparam logic [7:0]  FCL_UPPER_ONES  = 8'hFF;
    localparam logic [7:0]  FCL_PRESC_LONG  = 8'h80;      // 1:128
    localparam logic [7:0]  FCL_PRESC_SHORT = 8'h20;      // 1:32
    localparam logic [15:0] FCL_POST_UNIT   = 16'h0001;   // 1:1
    localparam logic [1:0]  FCL_PAIR_ONE    = 2'h3;
    localparam logic [1:0]  FCL_PAIR_TWO    = 2'h2;
    localparam logic [1:0]  FCL_PAIR_THREE  = 2'h1;
    localparam logic [1:0]  FCL_PRIME_LAST  = 2'h3;       // strap settle

    // -------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        FCL_ST_PRIME,
        FCL_ST_FETCH_ONE,
        FCL_ST_FETCH_TWO,
        FCL_ST_DONE
    } fcl_state_t;

    typedef struct packed
    {
        logic        scan_port_enable;
        logic        code_protect_on;
        logic        write_protect_on;
        logic        debug_entry;
        logic [1:0]  emulator_pin_pair_select;
        logic [2:0]  pin_pair_onehot;
        logic        pin_pair_reserved;
        logic        watchdog_enable_cfg;
        logic        window_mode_on;
        logic        window_misconfig;
        logic [7:0]  watchdog_prescale_ratio;
        logic [3:0]  watchdog_postscale_select;
        logic [15:0] watchdog_postscale_ratio;
        logic        reserved_fault;
    } fcl_fields_t;

    typedef struct packed
    {
        logic        rd;
        logic [23:0] addr;
    } fcl_flash_req_t;

    typedef struct packed
    {
        logic        rd;
        logic        wr;
        logic [23:0] addr;
        logic [15:0] wdata;
    } fcl_tbl_req_t;

endpackage

// File: core/fcl_field_decode.sv
// fcl_field_decode: turns the packed word 1 image into decoded options
`timescale 1ns/1ps
`default_nettype none

module fcl_field_decode
(
    input  wire logic [23:0]         word_one, // word 1 image
    output fcl_pkg::fcl_fields_t     fields    // decoded options
);

    // -------------------------------------------------------------------
    // decode
    // -------------------------------------------------------------------
    // every bit reads 1 when erased, so an erased part decodes with both
    // protections off, debug entry off and the watchdog enabled
    always_comb
    begin
        fields = '0;
        fields.scan_port_enable  = word_one[fcl_pkg::FCL_BIT_SCAN];
        fields.code_protect_on   = ~word_one[fcl_pkg::FCL_BIT_CPROT];
        fields.write_protect_on  = ~word_one[fcl_pkg::FCL_BIT_WPROT];
        fields.debug_entry       = ~word_one[fcl_pkg::FCL_BIT_DEBUG];
        fields.emulator_pin_pair_select =
            word_one[fcl_pkg::FCL_PAIR_LO +: 2];
        // pin pair one-hot; the reserved code drives no pair at all
        if (word_one[fcl_pkg::FCL_PAIR_LO +: 2] == fcl_pkg::FCL_PAIR_ONE)
            fields.pin_pair_onehot = 3'h1;
        else if (word_one[fcl_pkg::FCL_PAIR_LO +: 2] == fcl_pkg::FCL_PAIR_TWO)
            fields.pin_pair_onehot = 3'h2;
        else if (word_one[fcl_pkg::FCL_PAIR_LO +: 2] == fcl_pkg::FCL_PAIR_THREE)
            fields.pin_pair_onehot = 3'h4;
        else
            fields.pin_pair_reserved = 1'b1;
        fields.watchdog_enable_cfg = word_one[fcl_pkg::FCL_BIT_WDTEN];
        // windowed mode only takes effect with the watchdog enabled
        fields.window_mode_on = word_one[fcl_pkg::FCL_BIT_WDTEN]
                              & ~word_one[fcl_pkg::FCL_BIT_WINDOW_WATCHDOG_DISABLE];
        fields.window_misconfig = ~word_one[fcl_pkg::FCL_BIT_WDTEN]
                                & ~word_one[fcl_pkg::FCL_BIT_WINDOW_WATCHDOG_DISABLE];
        fields.watchdog_prescale_ratio = word_one[fcl_pkg::FCL_BIT_PRESC]
                                       ? fcl_pkg::FCL_PRESC_LONG
                                       : fcl_pkg::FCL_PRESC_SHORT;
        fields.watchdog_postscale_select =
            word_one[fcl_pkg::FCL_POST_LO +: 4];
        fields.watchdog_postscale_ratio = fcl_pkg::FCL_POST_UNIT
            << word_one[fcl_pkg::FCL_POST_LO +: 4];
        // flag a part whose reserved bits were left wrong
        fields.reserved_fault = word_one[fcl_pkg::FCL_BIT_RSV_HI]
                              | ~word_one[fcl_pkg::FCL_BIT_RSV_LO];
    end

endmodule

`default_nettype wire

// File: core/fcl_config_loader.sv
// fcl_config_loader: reset-time loader of the flash configuration words
`timescale 1ns/1ps
`default_nettype none

module fcl_config_loader
(
    input  wire logic                  core_clk,       // system clock
    input  wire logic                  rstn,           // any reset, low
    input  wire logic [1:0]            mem_size_strap, // flash size pins
    output fcl_pkg::fcl_flash_req_t    flash_req,      // flash read req
    input  wire logic [23:0]           flash_rdata,    // flash read word
    input  wire logic                  flash_rvalid,   // flash data valid
    input  wire fcl_pkg::fcl_tbl_req_t tbl_req,        // table access
    output logic [15:0]                tbl_rdata,      // table read data
    output logic                       tbl_rvalid,     // read answer
    output logic                       tbl_hit,        // read in config space
    output logic                       tbl_wr_ignored, // write refused
    output logic [23:0]                word_one,       // word 1 image
    output logic [23:0]                word_two,       // word 2 image
    output fcl_pkg::fcl_fields_t       cfg_fields,     // decoded options
    output logic                       load_done,      // words loaded
    output logic                       dep_rstn        // dependents reset
);

    // -------------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------------
    fcl_pkg::fcl_state_t  state;        // loader state
    fcl_pkg::fcl_state_t  next_state;   // loader next state
    logic [1:0]           strap_meta;   // strap first stage
    logic [1:0]           strap_sync;   // strap second stage
    logic [1:0]           mem_size;     // captured size code
    logic [1:0]           prime_cnt;    // settle counter
    logic [23:0]          addr_one;     // word 1 address
    logic [23:0]          addr_two;     // word 2 address
    fcl_pkg::fcl_fields_t next_fields;  // decoder output
    logic [7:0]           loc [fcl_pkg::FCL_LOC_COUNT]; // unpacked slots
    logic [fcl_pkg::FCL_LOC_COUNT-1:0] loc_sel;         // slot match
    logic                 in_space;     // address in config space
    logic [7:0]           next_byte;    // selected slot value

    // -------------------------------------------------------------------
    // strap synchroniser
    // -------------------------------------------------------------------
    // the strap is a pin; two flops before anything looks at it
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            strap_meta <= 2'h0;
            strap_sync <= 2'h0;
        end
        else
        begin
            strap_meta <= mem_size_strap;
            strap_sync <= strap_meta;
        end
    end

    // settle counter, lets the synchroniser fill after release
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            prime_cnt <= 2'h0;
        else if (state == fcl_pkg::FCL_ST_PRIME)
            prime_cnt <= prime_cnt + 2'h1;
    end

    // size follows the strap only while in prime, then holds, so a late strap change is harmless
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            mem_size <= 2'h0;
        else if (state == fcl_pkg::FCL_ST_PRIME)
            mem_size <= strap_sync;
    end

    // -------------------------------------------------------------------
    // top-of-flash address lookup
    // -------------------------------------------------------------------
    always_comb
    begin
        if (mem_size == fcl_pkg::FCL_SIZE_16K)
        begin
            addr_one = fcl_pkg::FCL_W1_16K;
            addr_two = fcl_pkg::FCL_W2_16K;
        end
        else if (mem_size == fcl_pkg::FCL_SIZE_32K)
        begin
            addr_one = fcl_pkg::FCL_W1_32K;
            addr_two = fcl_pkg::FCL_W2_32K;
        end
        else if (mem_size == fcl_pkg::FCL_SIZE_48K)
        begin
            addr_one = fcl_pkg::FCL_W1_48K;
            addr_two = fcl_pkg::FCL_W2_48K;
        end
        else
        begin
            addr_one = fcl_pkg::FCL_W1_64K;
            addr_two = fcl_pkg::FCL_W2_64K;
        end
    end

    // -------------------------------------------------------------------
    // load sequencer
    // -------------------------------------------------------------------
    // every reset lands in prime, so every reset type reloads both words
    always_comb
    begin
        next_state = state;
        case (state)
            fcl_pkg::FCL_ST_PRIME:
                if (prime_cnt == fcl_pkg::FCL_PRIME_LAST)
                    next_state = fcl_pkg::FCL_ST_FETCH_ONE;
            fcl_pkg::FCL_ST_FETCH_ONE:
                if (flash_rvalid)
                    next_state = fcl_pkg::FCL_ST_FETCH_TWO;
            fcl_pkg::FCL_ST_FETCH_TWO:
                if (flash_rvalid)
                    next_state = fcl_pkg::FCL_ST_DONE;
            default:
                next_state = fcl_pkg::FCL_ST_DONE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            state <= fcl_pkg::FCL_ST_PRIME;
        else
            state <= next_state;
    end

    // read request held until the flash answers
    always_comb
    begin
        flash_req.rd   = (state == fcl_pkg::FCL_ST_FETCH_ONE)
                       | (state == fcl_pkg::FCL_ST_FETCH_TWO);
        flash_req.addr = (state == fcl_pkg::FCL_ST_FETCH_TWO)
                       ? addr_two : addr_one;
    end

    // -------------------------------------------------------------------
    // word images
    // -------------------------------------------------------------------
    // erased image at reset; upper byte stored as ones whatever was read
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            word_one <= fcl_pkg::FCL_ERASED;
            word_two <= fcl_pkg::FCL_ERASED;
        end
        else if (flash_rvalid && state == fcl_pkg::FCL_ST_FETCH_ONE)
            word_one <= {fcl_pkg::FCL_UPPER_ONES, flash_rdata[15:0]};
        else if (flash_rvalid && state == fcl_pkg::FCL_ST_FETCH_TWO)
            word_two <= {fcl_pkg::FCL_UPPER_ONES, flash_rdata[15:0]};
    end

    // done flag and dependent reset; both flop outputs, so no glitch
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            load_done <= 1'b0;
            dep_rstn  <= 1'b0;
        end
        else if (flash_rvalid && state == fcl_pkg::FCL_ST_FETCH_TWO)
        begin
            load_done <= 1'b1;
            dep_rstn  <= 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // option decode
    // -------------------------------------------------------------------
    fcl_field_decode u_decode
    (
        .word_one (word_one),
        .fields   (next_fields)
    );

    // registered so consumers see a clean value one cycle after the image
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            cfg_fields <= '0;
        else
            cfg_fields <= next_fields;
    end

    // -------------------------------------------------------------------
    // table access into configuration space
    // -------------------------------------------------------------------
    // unpack into five byte slots
    always_comb
    begin
        loc[0] = word_one[7:0];
        loc[1] = word_one[15:8];
        loc[2] = word_two[7:0];
        loc[3] = word_two[15:8];
        loc[4] = word_one[23:16] & word_two[23:16];
    end

    assign in_space = (tbl_req.addr >= fcl_pkg::FCL_SPACE_LO)
                    && (tbl_req.addr <= fcl_pkg::FCL_SPACE_HI);

    // one comparator per slot
    genvar gi;
    generate
        for (gi = 0; gi < fcl_pkg::FCL_LOC_COUNT; gi = gi + 1)
        begin : g_loc
            assign loc_sel[gi] = (tbl_req.addr == fcl_pkg::FCL_CFG_BASE
                + 24'(gi) * fcl_pkg::FCL_LOC_STEP);
        end
    endgenerate

    // unmatched config-space addresses read as erased ones
    always_comb
    begin
        next_byte = fcl_pkg::FCL_UPPER_ONES;
        for (int i = 0; i < fcl_pkg::FCL_LOC_COUNT; i++)
        begin
            if (loc_sel[i])
                next_byte = loc[i];
        end
    end

    // read answer one cycle after the request; data from flops
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tbl_rdata  <= 16'h0000;
            tbl_rvalid <= 1'b0;
            tbl_hit    <= 1'b0;
        end
        else
        begin
            tbl_rvalid <= tbl_req.rd;
            tbl_hit    <= tbl_req.rd && in_space;
            if (tbl_req.rd && in_space)
                tbl_rdata <= {fcl_pkg::FCL_UPPER_ONES, next_byte};
            else if (tbl_req.rd)
                tbl_rdata <= 16'h0000;
        end
    end

    // run-time writes never reach the images; only a pulse reports them
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            tbl_wr_ignored <= 1'b0;
        else
            tbl_wr_ignored <= tbl_req.wr && in_space;
    end

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_fetch_first_addr: assert property (
        state == fcl_pkg::FCL_ST_FETCH_ONE |-> flash_req.addr == addr_one)
        else $error("word 1 fetched from wrong address");

    a_fetch_order_two: assert property (
        state == fcl_pkg::FCL_ST_FETCH_ONE && flash_rvalid
        |=> flash_req.rd && flash_req.addr == addr_two)
        else $error("word 2 fetch did not follow word 1");

    a_dep_hold_reset: assert property (
        !load_done |-> !dep_rstn)
        else $error("dependents released before load");

    a_dep_release_cause: assert property (
        $rose(dep_rstn) |-> $past(state) == fcl_pkg::FCL_ST_FETCH_TWO
        && $past(flash_rvalid))
        else $error("dependents released without word 2");

    a_upper_byte_ones: assert property (
        word_one[23:16] == fcl_pkg::FCL_UPPER_ONES
        && word_two[23:16] == fcl_pkg::FCL_UPPER_ONES)
        else $error("upper byte not ones");

    a_scan_enable_bit: assert property (
        load_done && $past(load_done)
        |-> cfg_fields.scan_port_enable == $past(word_one[14]))
        else $error("scan enable mismatch");

    a_protect_bits: assert property (
        load_done && $past(load_done)
        |-> cfg_fields.code_protect_on == !$past(word_one[13])
        && cfg_fields.write_protect_on == !$past(word_one[12]))
        else $error("protection decode mismatch");

    a_debug_entry_bit: assert property (
        load_done && $past(load_done)
        |-> cfg_fields.debug_entry == !$past(word_one[11]))
        else $error("debug entry mismatch");

    a_prescale_ratio: assert property (
        load_done && $past(load_done)
        |-> cfg_fields.watchdog_prescale_ratio
        == ($past(word_one[4]) ? 8'h80 : 8'h20))
        else $error("prescale ratio wrong");

    a_postscale_ratio: assert property (
        load_done && $past(load_done)
        |-> cfg_fields.watchdog_postscale_ratio
        == (16'h0001 << $past(word_one[3:0])))
        else $error("postscale ratio wrong");

    a_window_needs_en: assert property (
        (cfg_fields.window_mode_on |-> cfg_fields.watchdog_enable_cfg)
        and (load_done && $past(load_done) |-> cfg_fields.window_mode_on
        == ($past(word_one[7]) && !$past(word_one[6]))))
        else $error("window mode without watchdog");

    a_write_no_effect: assert property (
        load_done && tbl_req.wr |=> $stable(word_one) && $stable(word_two)
        && tbl_wr_ignored == $past(in_space))
        else $error("run-time write changed image");

    a_table_answer: assert property (
        tbl_req.rd && !in_space |=> tbl_rvalid && !tbl_hit)
        else $error("out-of-space read answered as hit");

    c_load_complete: cover property ($rose(load_done));
    c_table_hit: cover property (tbl_hit && load_done);
    c_write_refused: cover property (tbl_wr_ignored);
    c_window_mode: cover property (load_done && cfg_fields.window_mode_on);

endmodule

`default_nettype wire

// File: dv/fcl_flash_model.sv
// fcl_flash_model: program flash array holding the two config words
`timescale 1ns/1ps
`default_nettype none

module fcl_flash_model
(
    input  wire logic                    core_clk, // system clock
    input  wire logic                    rstn,     // reset, low
    input  wire logic [23:0]             top_addr, // word 1 address
    input  wire logic [23:0]             img_one,  // stored word 1
    input  wire logic [23:0]             img_two,  // stored word 2
    input  wire logic [3:0]              lat,      // answer delay
    input  wire fcl_pkg::fcl_flash_req_t req,      // read request
    output logic [23:0]                  rdata,    // read word
    output logic                         rvalid    // answer pulse
);
    logic [3:0] wait_cnt; // cycles spent on the open read

    // ------------------------------------------------------------
    // answer after lat cycles; bus scrambled outside the answer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wait_cnt <= 4'h0;
            rvalid   <= 1'b0;
            rdata    <= 24'h5A5A5A;
        end
        else if (rvalid)
        begin
            // stale data must not look valid, so invert it
            rvalid <= 1'b0;
            rdata  <= ~rdata;
        end
        else if (req.rd && wait_cnt == lat)
        begin
            wait_cnt <= 4'h0;
            rvalid   <= 1'b1;
            // only the two top words hold config data
            if (req.addr == top_addr)
                rdata <= img_one;
            else if (req.addr == top_addr - 24'h000002)
                rdata <= img_two;
            else
                rdata <= ~rdata;
        end
        else if (req.rd)
            wait_cnt <= wait_cnt + 4'h1;
    end
endmodule
`default_nettype wire

// File: dv/test_flash_config_word_loader.sv
// test_flash_config_word_loader: self-checking bench of the loader
`timescale 1ns/1ps
`default_nettype none

module test_flash_config_word_loader;
    logic                    core_clk;    // 40 MHz clock
    logic                    rstn;        // reset, low
    logic [1:0]              strap;       // flash size pins
    logic [3:0]              lat;         // flash answer delay
    logic [23:0]             img_one;     // stored word 1
    logic [23:0]             img_two;     // stored word 2
    fcl_pkg::fcl_flash_req_t flash_req;   // read request
    logic [23:0]             flash_rdata; // read word
    logic                    flash_rvalid;// answer pulse
    fcl_pkg::fcl_tbl_req_t   tbl_req;     // table access
    logic [15:0]             tbl_rdata;   // table data
    logic                    tbl_rvalid;  // table answer
    logic                    tbl_hit;     // in config space
    logic                    wr_ign;      // write refused
    logic [23:0]             word_one;    // word 1 image
    logic [23:0]             word_two;    // word 2 image
    fcl_pkg::fcl_fields_t    fields;      // decoded options
    logic                    load_done;   // load finished
    logic                    dep_rstn;    // dependents reset
    logic [23:0]             top_addr;    // word 1 address
    int                      miscompares; // mismatches
    int                      checked;     // comparisons
    int                      cycles;      // hang guard

    assign top_addr = (strap == 2'h0) ? fcl_pkg::FCL_W1_16K :
                      (strap == 2'h1) ? fcl_pkg::FCL_W1_32K :
                      (strap == 2'h2) ? fcl_pkg::FCL_W1_48K :
                      fcl_pkg::FCL_W1_64K;

    fcl_config_loader uut (.core_clk(core_clk), .rstn(rstn),
        .mem_size_strap(strap), .flash_req(flash_req),
        .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid),
        .tbl_req(tbl_req), .tbl_rdata(tbl_rdata), .tbl_rvalid(tbl_rvalid),
        .tbl_hit(tbl_hit), .tbl_wr_ignored(wr_ign), .word_one(word_one),
        .word_two(word_two), .cfg_fields(fields), .load_done(load_done),
        .dep_rstn(dep_rstn));

    fcl_flash_model flash (.core_clk(core_clk), .rstn(rstn),
        .top_addr(top_addr), .img_one(img_one), .img_two(img_two),
        .lat(lat), .req(flash_req), .rdata(flash_rdata),
        .rvalid(flash_rvalid));

    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [47:0] seen,
                         input logic [47:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // expected decode of word 1, erased bit reads 1
    function automatic fcl_pkg::fcl_fields_t want(input logic [15:0] w);
        fcl_pkg::fcl_fields_t f;
        f.scan_port_enable          = w[14];
        f.code_protect_on           = ~w[13];
        f.write_protect_on          = ~w[12];
        f.debug_entry               = ~w[11];
        f.emulator_pin_pair_select  = w[9:8];
        f.pin_pair_onehot = (w[9:8] == 2'h3) ? 3'h1 :
                            (w[9:8] == 2'h2) ? 3'h2 :
                            (w[9:8] == 2'h1) ? 3'h4 : 3'h0;
        f.pin_pair_reserved         = (w[9:8] == 2'h0);
        f.watchdog_enable_cfg       = w[7];
        f.window_mode_on            = w[7] & ~w[6];
        f.window_misconfig          = ~w[7] & ~w[6];
        f.watchdog_prescale_ratio   = w[4] ? 8'h80 : 8'h20;
        f.watchdog_postscale_select = w[3:0];
        f.watchdog_postscale_ratio  = 16'h0001 << w[3:0];
        f.reserved_fault            = w[15] | ~w[10];
        return f;
    endfunction

    // reset, load words with upper byte 00, check images
    task automatic boot(input logic [1:0] s, input logic [3:0] l,
                        input logic [15:0] w1, input logic [15:0] w2);
        int n;
        @(posedge core_clk);
        strap   <= s;
        lat     <= l;
        img_one <= {8'h00, w1};
        img_two <= {8'h00, w2};
        rstn    <= 1'b0;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        #1;
        check("dep_rstn held", dep_rstn, 1'b0);
        n = 0;
        while (load_done !== 1'b1 && n < 80)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check("dep_rstn", dep_rstn, 1'b1);
        check("word_one", word_one, {8'hFF, w1});
        check("word_two", word_two, {8'hFF, w2});
        @(posedge core_clk);
        #1;
    endtask

    // one table access; read checks answer, write checks refusal
    task automatic tbl(input logic w, input logic [23:0] a,
                       input logic [15:0] exp, input logic hit);
        @(posedge core_clk);
        tbl_req <= '{rd: ~w, wr: w, addr: a, wdata: 16'h0000};
        @(posedge core_clk);
        tbl_req <= '0;
        #1;
        if (w)
            check("wr_ignored", wr_ign, hit);
        else
            check("tbl_read", {tbl_rvalid, tbl_hit, tbl_rdata},
                  {1'b1, hit, exp});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_sizes();
        for (int s = 0; s < 4; s++)
            boot(s[1:0], s[3:0], 16'h4CA5 ^ s[15:0], 16'h1234 + s[15:0]);
    endtask

    task automatic t_decode();
        logic [15:0] w;
        for (int i = 0; i < 16; i++)
        begin
            w = {1'b0, i[1], i[0], i[2], i[3], 1'b1, i[1:0], i[2], i[1],
                 1'b1, i[0], i[3:0]};
            boot(2'h3, 4'h1, w, 16'hFFFF);
            check("fields", fields, want(w));
        end
    endtask

    task automatic t_table();
        boot(2'h2, 4'h2, 16'h4DB6, 16'hC3A1);
        tbl(1'b0, 24'hF80000, 16'hFFB6, 1'b1);
        tbl(1'b0, 24'hF80002, 16'hFF4D, 1'b1);
        tbl(1'b0, 24'hF80004, 16'hFFA1, 1'b1);
        tbl(1'b0, 24'hF80006, 16'hFFC3, 1'b1);
        tbl(1'b0, 24'hF80008, 16'hFFFF, 1'b1);
        tbl(1'b0, 24'h800000, 16'hFFFF, 1'b1);
        tbl(1'b0, 24'h7FFFFE, 16'h0000, 1'b0);
        tbl(1'b1, 24'hF80000, 16'h0000, 1'b1);
        tbl(1'b1, 24'h001000, 16'h0000, 1'b0);
        check("word_one kept", word_one, 24'hFF4DB6);
    endtask

    initial
    begin
        rstn        = 1'b0;
        strap       = 2'h3;
        lat         = 4'h0;
        img_one     = 24'hFFFFFF;
        img_two     = 24'hFFFFFF;
        tbl_req     = '0;
        miscompares = 0;
        checked     = 0;
        cycles      = 0;
        t_sizes();
        t_decode();
        t_table();
        conclude();
    end
endmodule
`default_nettype wire
